/* core/lsw_board.sv */
// Top of the load switching and fault injection board controller
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module lsw_board #(
  parameter int unsigned NUM_CH = lsw_pkg::NUM_CH
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          RESETN,
  // Board straps
  input  wire logic                          FUNC_FAULT_STRAP,
  input  wire logic [lsw_pkg::ADR_W-1:0]     BASE_ADDR,
  // Wishbone classic slave
  input  wire logic                          WB_CYC_I,
  input  wire logic                          WB_STB_I,
  input  wire logic                          WB_WE_I,
  input  wire logic [lsw_pkg::ADR_W-1:0]     WB_ADR_I,
  input  wire logic [3:0]                    WB_SEL_I,
  input  wire logic [lsw_pkg::DAT_W-1:0]     WB_DAT_I,
  output logic      [lsw_pkg::DAT_W-1:0]     WB_DAT_O,
  output logic                               WB_ACK_O,
  // Analog front end
  input  wire logic                          FUSE_BLOWN,
  input  wire logic [NUM_CH-1:0]             CMP_ABOVE_LOW,
  input  wire logic [NUM_CH-1:0]             CMP_ABOVE_HIGH,
  // Switch drives
  output logic      [NUM_CH-1:0]             ROUTE_LOAD_B,
  output logic      [NUM_CH-1:0]             PROBE_CONNECT,
  output logic      [NUM_CH-1:0]             SHORT_TO_BAT,
  output logic      [NUM_CH-1:0]             SHORT_TO_GND,
  output logic      [NUM_CH-1:0]             LINE_INTERRUPT,
  output logic      [NUM_CH*lsw_pkg::CODE_W-1:0] LEVEL_LED,
  output logic                               XFER_REQ
);
  localparam int unsigned CW  = lsw_pkg::CODE_W;
  localparam int unsigned SW  = lsw_pkg::SEL_W;
  localparam int unsigned DW  = lsw_pkg::DAT_W;
  localparam int unsigned STW = NUM_CH * CW + 1;

  // Strap capture after reset release
  lsw_pkg::board_func_t func_r;
  logic                 strap_done_r;
  logic [lsw_pkg::ADR_W-1:0] base_r;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      func_r       <= lsw_pkg::FUNC_TOGGLE;
      base_r       <= '0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      func_r       <= FUNC_FAULT_STRAP ? lsw_pkg::FUNC_FAULT
                                       : lsw_pkg::FUNC_TOGGLE;
      base_r       <= BASE_ADDR;
      strap_done_r <= 1'b1;
    end
  end

  logic is_fault;
  logic is_toggle;
  always_comb begin
    case (func_r)
      lsw_pkg::FUNC_FAULT: begin
        is_fault  = 1'b1;
        is_toggle = 1'b0;
      end
      lsw_pkg::FUNC_TOGGLE: begin
        is_fault  = 1'b0;
        is_toggle = 1'b1;
      end
      default: begin
        is_fault  = 1'b0;
        is_toggle = 1'b0;
      end
    endcase
  end

  // Bus decode
  logic       hit;
  logic       req;
  logic       wr_en;
  logic [7:0] ofs;
  logic       ack_r;

  assign hit = strap_done_r &&
               (WB_ADR_I[lsw_pkg::ADR_W-1:lsw_pkg::BASE_LSB] ==
                base_r[lsw_pkg::ADR_W-1:lsw_pkg::BASE_LSB]);
  assign req   = WB_CYC_I && WB_STB_I && hit;
  assign ofs   = {WB_ADR_I[lsw_pkg::BASE_LSB-1:lsw_pkg::IDX_LSB], 2'h0};
  // Write lands on the edge the master sees ack
  assign wr_en = req && WB_WE_I && ack_r;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end
  assign WB_ACK_O = ack_r;

  // Software registers
  logic              onchg_r;
  logic [SW-1:0]     probe_r;
  logic [SW-1:0]     fchan_r;
  logic [SW-1:0]     ftype_r;
  logic [NUM_CH-1:0] route_r;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      onchg_r <= lsw_pkg::ONCHG_RST;
    end else if (wr_en && ofs == lsw_pkg::OFS_CTRL && WB_SEL_I[0]) begin
      onchg_r <= WB_DAT_I[lsw_pkg::CTRL_ONCHG_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      probe_r <= lsw_pkg::SEL_NONE_RST;
    end else if (wr_en && ofs == lsw_pkg::OFS_PROBE && WB_SEL_I[0]) begin
      probe_r <= WB_DAT_I[SW-1:0];
    end
  end

  // Fault controls only take writes on a fault-injection board
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fchan_r <= lsw_pkg::SEL_NONE_RST;
      ftype_r <= lsw_pkg::FTYPE_RST;
    end else if (wr_en && is_fault && WB_SEL_I[0]) begin
      if (ofs == lsw_pkg::OFS_FCHAN) begin
        fchan_r <= WB_DAT_I[SW-1:0];
      end
      if (ofs == lsw_pkg::OFS_FTYPE) begin
        ftype_r <= WB_DAT_I[SW-1:0];
      end
    end
  end

  // Route controls only take writes on a load-toggling board
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      route_r <= lsw_pkg::ROUTE_RST;
    end else if (wr_en && is_toggle && ofs == lsw_pkg::OFS_ROUTE) begin
      if (WB_SEL_I[0]) begin
        route_r[7:0] <= WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        route_r[NUM_CH-1:8] <= WB_DAT_I[NUM_CH-1:8];
      end
    end
  end

  // Level comparison
  logic [NUM_CH*CW-1:0] codes;

  lsw_level_classifier #(
    .NUM_CH (NUM_CH)
  ) u_levels (
    .REF_CLK    (REF_CLK),
    .RESETN     (RESETN),
    .above_low  (CMP_ABOVE_LOW),
    .above_high (CMP_ABOVE_HIGH),
    .codes      (codes)
  );

  // Fuse sample
  logic fuse_r;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fuse_r <= 1'b0;
    end else begin
      fuse_r <= FUSE_BLOWN;
    end
  end

  // Status change detection for data-dependent transfer
  logic [STW-1:0] snap_r;
  logic           chg_r;
  logic           chg_set;
  logic           chg_clr;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      snap_r <= '0;
    end else begin
      snap_r <= {fuse_r, codes};
    end
  end

  assign chg_set = (snap_r != {fuse_r, codes});
  assign chg_clr = wr_en && ofs == lsw_pkg::OFS_STATUS && WB_SEL_I[0] &&
                   WB_DAT_I[lsw_pkg::STAT_CHG_BIT];

  // Set wins over a clear in the same cycle
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      chg_r <= 1'b0;
    end else if (chg_set) begin
      chg_r <= 1'b1;
    end else if (chg_clr) begin
      chg_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      XFER_REQ <= 1'b0;
    end else begin
      XFER_REQ <= !onchg_r || chg_r;
    end
  end

  // Fault decode
  logic [NUM_CH-1:0] bat_nxt;
  logic [NUM_CH-1:0] gnd_nxt;
  logic [NUM_CH-1:0] int_nxt;

  lsw_fault_decoder #(
    .NUM_CH (NUM_CH)
  ) u_fault (
    .enable    (is_fault),
    .chan_sel  (fchan_r),
    .type_sel  (ftype_r),
    .short_bat (bat_nxt),
    .short_gnd (gnd_nxt),
    .interrupt (int_nxt)
  );

  // Probe decode
  logic [NUM_CH-1:0] probe_nxt;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_probe
      assign probe_nxt[g] = (probe_r == SW'(g));
    end
  endgenerate

  // Registered switch drives
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SHORT_TO_BAT   <= '0;
      SHORT_TO_GND   <= '0;
      LINE_INTERRUPT <= '0;
    end else begin
      SHORT_TO_BAT   <= bat_nxt;
      SHORT_TO_GND   <= gnd_nxt;
      LINE_INTERRUPT <= int_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ROUTE_LOAD_B <= '0;
    end else begin
      // Fault board keeps every port on its normal load A path
      ROUTE_LOAD_B <= is_toggle ? route_r : '0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PROBE_CONNECT <= '0;
    end else begin
      PROBE_CONNECT <= probe_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      LEVEL_LED <= '0;
    end else begin
      LEVEL_LED <= codes;
    end
  end

  // Read mux
  logic [DW-1:0] rd_nxt;
  always_comb begin
    rd_nxt = '0;
    case (ofs)
      lsw_pkg::OFS_CTRL: begin
        rd_nxt[lsw_pkg::CTRL_ONCHG_BIT] = onchg_r;
        rd_nxt[lsw_pkg::CTRL_FUNC_BIT]  = is_fault;
      end
      lsw_pkg::OFS_PROBE: begin
        rd_nxt[SW-1:0] = probe_r;
      end
      lsw_pkg::OFS_FCHAN: begin
        rd_nxt[SW-1:0] = is_fault ? fchan_r : '0;
      end
      lsw_pkg::OFS_FTYPE: begin
        rd_nxt[SW-1:0] = is_fault ? ftype_r : '0;
      end
      lsw_pkg::OFS_ROUTE: begin
        rd_nxt[NUM_CH-1:0] = is_toggle ? route_r : '0;
      end
      lsw_pkg::OFS_STATUS: begin
        rd_nxt[lsw_pkg::STAT_FUSE_BIT] = fuse_r;
        rd_nxt[lsw_pkg::STAT_CHG_BIT]  = chg_r;
      end
      lsw_pkg::OFS_LEVEL: begin
        rd_nxt[NUM_CH*CW-1:0] = codes;
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      WB_DAT_O <= '0;
    end else if (req && !ack_r) begin
      WB_DAT_O <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

/* core/lsw_fault_decoder.sv */
// Decodes fault channel and type into per-channel switch drives
`timescale 1ns/100ps
`default_nettype none
module lsw_fault_decoder #(
  parameter int unsigned NUM_CH = lsw_pkg::NUM_CH
) (
  input  wire logic                     enable,
  input  wire logic [lsw_pkg::SEL_W-1:0] chan_sel,
  input  wire logic [lsw_pkg::SEL_W-1:0] type_sel,
  output logic      [NUM_CH-1:0]        short_bat,
  output logic      [NUM_CH-1:0]        short_gnd,
  output logic      [NUM_CH-1:0]        interrupt
);
  logic is_bat;
  logic is_gnd;

  assign is_bat = (type_sel == lsw_pkg::FT_BAT);
  assign is_gnd = (type_sel == lsw_pkg::FT_GND);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic hit;
      // Exact match: at most one channel, none when out of range
      assign hit = enable && (chan_sel == lsw_pkg::SEL_W'(g));
      assign short_bat[g] = hit && is_bat;
      assign short_gnd[g] = hit && is_gnd;
      assign interrupt[g] = hit && !is_bat && !is_gnd;
    end
  endgenerate
endmodule
`default_nettype wire

/* core/lsw_level_classifier.sv */
// Per-channel threshold comparison to level codes
`timescale 1ns/100ps
`default_nettype none
module lsw_level_classifier #(
  parameter int unsigned NUM_CH = lsw_pkg::NUM_CH
) (
  input  wire logic                                REF_CLK,
  input  wire logic                                RESETN,
  input  wire logic [NUM_CH-1:0]                   above_low,
  input  wire logic [NUM_CH-1:0]                   above_high,
  output logic      [NUM_CH*lsw_pkg::CODE_W-1:0]   codes
);
  localparam int unsigned CW = lsw_pkg::CODE_W;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [CW-1:0] code_nxt;
      always_comb begin
        if (above_high[g]) begin
          code_nxt = lsw_pkg::LVL_HIGH;
        end else if (!above_low[g]) begin
          code_nxt = lsw_pkg::LVL_LOW;
        end else begin
          code_nxt = lsw_pkg::LVL_OPEN;
        end
      end
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          codes[g*CW +: CW] <= lsw_pkg::LVL_LOW;
        end else begin
          codes[g*CW +: CW] <= code_nxt;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* core/lsw_pkg.sv */
// Shared constants for the load switching and fault injection board
package lsw_pkg;
  localparam int unsigned NUM_CH   = 14;
  localparam int unsigned SEL_W    = 8;
  localparam int unsigned CODE_W   = 2;
  localparam int unsigned ADR_W    = 32;
  localparam int unsigned DAT_W    = 32;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned IDX_W    = 6;
  localparam int unsigned BASE_LSB = 8;

  // Word addresses (byte offsets) of the registers
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PROBE  = 8'h04;
  localparam logic [7:0] OFS_FCHAN  = 8'h08;
  localparam logic [7:0] OFS_FTYPE  = 8'h0C;
  localparam logic [7:0] OFS_ROUTE  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_LEVEL  = 8'h18;

  // Field positions
  localparam int unsigned CTRL_ONCHG_BIT = 0;
  localparam int unsigned CTRL_FUNC_BIT  = 1;
  localparam int unsigned STAT_FUSE_BIT  = 0;
  localparam int unsigned STAT_CHG_BIT   = 1;

  // Level codes
  localparam logic [CODE_W-1:0] LVL_LOW  = 2'h0;
  localparam logic [CODE_W-1:0] LVL_HIGH = 2'h1;
  localparam logic [CODE_W-1:0] LVL_OPEN = 2'h2;

  // Fault type codes
  localparam logic [SEL_W-1:0] FT_BAT = 8'h01;
  localparam logic [SEL_W-1:0] FT_GND = 8'h02;

  // Reset values
  localparam logic [SEL_W-1:0]  SEL_NONE_RST = 8'hFF;
  localparam logic [SEL_W-1:0]  FTYPE_RST    = 8'h00;
  localparam logic [NUM_CH-1:0] ROUTE_RST    = 14'h0000;
  localparam logic              ONCHG_RST    = 1'b1;

  typedef enum logic [1:0] {
    FUNC_TOGGLE = 2'b01,
    FUNC_FAULT  = 2'b10
  } board_func_t;
endpackage

/* verif/lsw_board_checker.sv */
// Port-level assertions for the board controller
`timescale 1ns/100ps
`default_nettype none
module lsw_board_checker #(
  parameter int unsigned NUM_CH = lsw_pkg::NUM_CH
) (
  input wire logic                        REF_CLK,
  input wire logic                        RESETN,
  input wire logic                        FUNC_FAULT_STRAP,
  input wire logic [lsw_pkg::ADR_W-1:0]   BASE_ADDR,
  input wire logic                        WB_CYC_I,
  input wire logic                        WB_STB_I,
  input wire logic [lsw_pkg::ADR_W-1:0]   WB_ADR_I,
  input wire logic                        WB_ACK_O,
  input wire logic [NUM_CH-1:0]           CMP_ABOVE_LOW,
  input wire logic [NUM_CH-1:0]           CMP_ABOVE_HIGH,
  input wire logic [NUM_CH-1:0]           ROUTE_LOAD_B,
  input wire logic [NUM_CH-1:0]           PROBE_CONNECT,
  input wire logic [NUM_CH-1:0]           SHORT_TO_BAT,
  input wire logic [NUM_CH-1:0]           SHORT_TO_GND,
  input wire logic [NUM_CH-1:0]           LINE_INTERRUPT,
  input wire logic [NUM_CH*lsw_pkg::CODE_W-1:0] LEVEL_LED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_in_window: assert property (
    $rose(WB_CYC_I) && WB_STB_I &&
    WB_ADR_I[31:8] == BASE_ADDR[31:8] |=> WB_ACK_O)
    else $error("access in window not acked next cycle");
  a_no_foreign_ack: assert property (
    WB_CYC_I && WB_STB_I &&
    WB_ADR_I[31:8] != BASE_ADDR[31:8] |=> !WB_ACK_O)
    else $error("access outside window acked");
  a_probe_one_hot: assert property ($onehot0(PROBE_CONNECT))
    else $error("more than one probe channel connected");
  a_single_fault: assert property (
    $onehot0({SHORT_TO_BAT, SHORT_TO_GND, LINE_INTERRUPT}))
    else $error("more than one fault drive active");
  a_toggle_no_fault: assert property (
    !FUNC_FAULT_STRAP |->
    {SHORT_TO_BAT, SHORT_TO_GND, LINE_INTERRUPT} == '0)
    else $error("fault drive on a toggle board");
  a_fault_no_route: assert property (
    FUNC_FAULT_STRAP |-> ROUTE_LOAD_B == '0)
    else $error("load B route on a fault board");
  // Four cycles: LEVEL_LED lags the comparators by two register stages, codes then LEVEL_LED
  a_level_open: assert property (
    (CMP_ABOVE_LOW[2] && !CMP_ABOVE_HIGH[2])[*4]
    |-> LEVEL_LED[5:4] == lsw_pkg::LVL_OPEN)
    else $error("between-threshold code not shown");
endmodule
`default_nettype wire

/* verif/lsw_board_tb_top.sv */
// Self-checking bench for the board controller
`timescale 1ns/100ps
`default_nettype none
module lsw_board_tb_top;
  localparam logic [31:0] BASE = 32'h1234_5600;
  logic        clk = 1'b0, rstn = 1'b0, strap = 1'b0, fuse = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, xfer;
  logic [3:0]  sel = 4'h0, lanes = 4'hF;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, q;
  logic [13:0] lo, hi, route, probe, sbat, sgnd, intr;
  logic [27:0] led;
  logic [15:0] mv [14];
  int          n_errors = 0, total_checks = 0, cycles = 0;

  always #5 clk = ~clk;
  lsw_link_model u_lsw_link_model (.mv(mv), .above_low(lo), .above_high(hi));
  lsw_board u_lsw_board (.REF_CLK(clk), .RESETN(rstn),
    .FUNC_FAULT_STRAP(strap), .BASE_ADDR(BASE), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .FUSE_BLOWN(fuse),
    .CMP_ABOVE_LOW(lo), .CMP_ABOVE_HIGH(hi), .ROUTE_LOAD_B(route),
    .PROBE_CONNECT(probe), .SHORT_TO_BAT(sbat), .SHORT_TO_GND(sgnd),
    .LINE_INTERRUPT(intr), .LEVEL_LED(led), .XFER_REQ(xfer));

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    sel  <= lanes;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] o,
                    input logic [31:0] e);
    wb(1'b0, {BASE[31:8], o}, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    rstn  <= 1'b0;
    strap <= s;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_toggle_regs;
    rd("ctrl", 8'h00, 32'h1);
    rd("probe", 8'h04, 32'hFF);
    rd("route", 8'h10, 32'h0);
    wb(1'b1, {BASE[31:8], 8'h08}, 32'h3);
    rd("fchan", 8'h08, 32'h0);
    wb(1'b1, {BASE[31:8], 8'h1C}, 32'h5);
    rd("unmapped", 8'h1C, 32'h0);
    wb(1'b1, {BASE[31:8], 8'h10}, 32'h2AAA);
    settle();
    chk("route pins", 32'h2AAA, route);
    rd("route", 8'h10, 32'h2AAA);
    lanes = 4'h1;
    wb(1'b1, {BASE[31:8], 8'h10}, 32'h1555);
    lanes = 4'hF;
    rd("route lane0", 8'h10, 32'h2A55);
  endtask

  task automatic t_foreign;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= BASE + 32'h100;
    repeat (4) @(posedge clk);
    chk("foreign ack", 32'h0, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic t_probe;
    for (int v = 0; v < 16; v++) begin
      wb(1'b1, {BASE[31:8], 8'h04}, (v == 15) ? 32'hFF : v);
      settle();
      chk("probe pins", (v < 14) ? 32'h1 << v : 32'h0, probe);
    end
  endtask

  task automatic t_levels;
    mv[0] = 16'h03E8;
    mv[1] = 16'h0DAC;
    mv[2] = 16'h0A8C;
    mv[3] = 16'h09C4;
    mv[4] = 16'h0BB8;
    settle();
    chk("led", 32'h2A4, led);
    rd("level", 8'h18, 32'h2A4);
    fuse <= 1'b1;
    settle();
    rd("status", 8'h14, 32'h3);
    chk("xfer on change", 32'h1, xfer);
    fuse <= 1'b0;
    settle();
    wb(1'b1, {BASE[31:8], 8'h14}, 32'h2);
    settle();
    rd("status clr", 8'h14, 32'h0);
    chk("xfer idle", 32'h0, xfer);
    wb(1'b1, {BASE[31:8], 8'h00}, 32'h0);
    settle();
    chk("xfer every", 32'h1, xfer);
  endtask

  task automatic t_fault;
    logic [7:0] ty [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
    do_reset(1'b1);
    rd("ctrl fault", 8'h00, 32'h3);
    wb(1'b1, {BASE[31:8], 8'h10}, 32'h3FFF);
    settle();
    chk("route fault", 32'h0, route);
    wb(1'b1, {BASE[31:8], 8'h08}, 32'hD);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, {BASE[31:8], 8'h0C}, {24'h0, ty[i]});
      settle();
      chk("bat", (i == 0) ? 32'h2000 : 32'h0, sbat);
      chk("gnd", (i == 1) ? 32'h2000 : 32'h0, sgnd);
      chk("intr", (i > 1) ? 32'h2000 : 32'h0, intr);
    end
    wb(1'b1, {BASE[31:8], 8'h08}, 32'hE);
    wb(1'b1, {BASE[31:8], 8'h0C}, 32'h1);
    settle();
    chk("off", 32'h0, {sbat, sgnd, intr} != 42'h0);
  endtask

  initial begin
    for (int i = 0; i < 14; i++) mv[i] = 16'h0000;
    do_reset(1'b0);
    t_toggle_regs();
    t_foreign();
    t_probe();
    t_levels();
    t_fault();
    close_out();
  end
endmodule

bind lsw_board lsw_board_checker #(.NUM_CH(NUM_CH)) u_lsw_board_checker (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .FUNC_FAULT_STRAP(FUNC_FAULT_STRAP),
  .BASE_ADDR(BASE_ADDR), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .CMP_ABOVE_LOW(CMP_ABOVE_LOW),
  .CMP_ABOVE_HIGH(CMP_ABOVE_HIGH), .ROUTE_LOAD_B(ROUTE_LOAD_B),
  .PROBE_CONNECT(PROBE_CONNECT), .SHORT_TO_BAT(SHORT_TO_BAT),
  .SHORT_TO_GND(SHORT_TO_GND), .LINE_INTERRUPT(LINE_INTERRUPT),
  .LEVEL_LED(LEVEL_LED));
`default_nettype wire

/* verif/lsw_link_model.sv */
// Far-side model: channel voltages in millivolts to comparator levels
`timescale 1ns/100ps
`default_nettype none
module lsw_link_model (
  input  wire logic [15:0]                 mv [lsw_pkg::NUM_CH],
  output logic      [lsw_pkg::NUM_CH-1:0]  above_low,
  output logic      [lsw_pkg::NUM_CH-1:0]  above_high
);
  always_comb begin
    for (int i = 0; i < lsw_pkg::NUM_CH; i++) begin
      above_low[i]  = mv[i] >= 16'h09C4;
      above_high[i] = mv[i] > 16'h0BB8;
    end
  end
endmodule
`default_nettype wire
